// ===== srwn_pkg.sv
// Constants for the soft reset and wake notification block
// ----------------------------------------------------------------------------
// How it works
// - Bit 6 resets controller core; clears itself when core leaves reset.
// - Bit 2 resets port B transceiver at least 102 us; then self-clears.
// - Bit 1 resets port A transceiver at least 102 us; then self-clears.
// - Writes to a set self-clearing bit are ignored; all read zero at reset.
// - Bit 0 resets the chip except PLL, transceivers and reset-immune bits.
// - Chip logic reset aborts any EEPROM command in progress.
// - Chip logic reset bit clears itself when the chip leaves reset.
// - Reset register stays readable in reset, not-ready and sleep states.
// - Reset register accepts partial byte accesses; host reads needed bytes.
// - Energy seen in energy-detect power-down wakes port and flags it.
// - Carrier present at energy-detect enable raises event at once.
// - Transceiver irqs show at status bits 26 and 27, may drive irq pin.
// - Any transceiver irq sets that port's wake status bit.
// - Wake-on-LAN frame detection by each port sets its wake flag.
// - Wake status bits latched, ANDed with enables, ORed into wake irq.
// - Wake irq status sets regardless of enable; status AND enable to pin.
// - Wake pin driven by wake event only when pin enable is set.
// - Buffer, polarity, pulse bits pick drive style and 50 ms pulse.
// - Pin map routes wake output; mapped but disabled stays undriven.
// - Auto wake enable wakes system independent of pin settings.
// - EEPROM load failure forces error LED function enabled.
// - Both wake status bits readable in power control register.
// - After chip logic reset, reload EEPROM; straps are not relatched.
// - During core reset host interfaces stay off until the core reset bit clears.
// ----------------------------------------------------------------------------
package srwn_pkg;
  localparam logic [11:0] SRWN_SOFT_RESET_REG_OFS = 12'h01f8;
  localparam logic [11:0] SRWN_PWR_CTL_OFS = 12'h0084;
  localparam logic [11:0] SRWN_IRQ_STS_OFS = 12'h0058;
  localparam logic [11:0] SRWN_IRQ_EN_OFS = 12'h005c;
  localparam int SRWN_BIT_CHIP = 0;
  localparam int SRWN_BIT_XA = 1;
  localparam int SRWN_BIT_XB = 2;
  localparam int SRWN_BIT_CORE = 6;
  localparam int SRWN_IRQ_XA = 26;
  localparam int SRWN_IRQ_XB = 27;
  localparam int SRWN_IRQ_WAKE = 17;
  // Power control field positions
  localparam int SRWN_PC_EN = 1;
  localparam int SRWN_PC_POL = 2;
  localparam int SRWN_PC_BUF = 3;
  localparam int SRWN_PC_IND = 4;
  localparam int SRWN_PC_AUTO = 5;
  localparam int SRWN_PC_ENA = 8;
  localparam int SRWN_PC_ENB = 9;
  localparam int SRWN_PC_STA = 16;
  localparam int SRWN_PC_STB = 17;
  localparam int SRWN_PC_MAP_LO = 12;
  localparam int SRWN_MAP_W = 3;
  localparam int SRWN_IRQEN_WAKE = 17;
  localparam int SRWN_CLK_MHZ = 125;
  localparam int SRWN_XCVR_HOLD_US = 102;
  localparam int SRWN_XCVR_HOLD_CYC = SRWN_XCVR_HOLD_US * SRWN_CLK_MHZ;
  localparam int SRWN_PULSE_MS = 50;
  localparam int SRWN_PULSE_CYC = SRWN_PULSE_MS * 1000 * SRWN_CLK_MHZ;
  localparam logic [31:0] SRWN_ZERO = 32'h0000_0000;
endpackage

// ===== srwn_hold_timer.sv
// Minimum-hold reset timer for one transceiver
`timescale 1ns/10ps
module srwn_hold_timer #(
  parameter int HOLD_CYC = 12750
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic start_i,
  output logic busy_o
);
  logic [23:0] cnt_q;

  // Load on start, count down to zero; busy while nonzero
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      cnt_q <= 24'h00_0000;
    end else if (start_i && cnt_q == 24'h00_0000) begin
      cnt_q <= 24'(HOLD_CYC);
    end else if (cnt_q != 24'h00_0000) begin
      cnt_q <= cnt_q - 24'h00_0001;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= (start_i && cnt_q == 24'h00_0000) || cnt_q > 24'h00_0001;
    end
  end
endmodule

// ===== srwn_top.sv
// Soft reset register and wake notification logic
`timescale 1ns/10ps
module srwn_top #(
  parameter int XCVR_HOLD_CYC = srwn_pkg::SRWN_XCVR_HOLD_CYC,
  parameter int PULSE_CYC = srwn_pkg::SRWN_PULSE_CYC
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Register port
  input wire logic [11:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [3:0] reg_be_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  // Reset handshakes
  input wire logic core_done_i,
  input wire logic chip_done_i,
  input wire logic eeprom_load_err_i,
  output logic core_controller_reset_o,
  output logic port_a_transceiver_reset_o,
  output logic port_b_transceiver_reset_o,
  output logic chip_logic_reset_o,
  output logic eeprom_abort_o,
  output logic eeprom_reload_o,
  output logic host_if_enable_o,
  // Transceiver events
  input wire logic port_a_xcvr_irq_i,
  input wire logic port_b_xcvr_irq_i,
  // Wake outputs
  output logic host_irq_o,
  output logic auto_wake_o,
  output logic error_led_force_o,
  output logic [7:0] wake_pin_out_o,
  output logic [7:0] wake_pin_oe_o
);
  logic core_q, xa_q, xb_q, chip_q;
  logic core_done_s1_q, core_done_s2_q, chip_done_s1_q, chip_done_s2_q;
  logic irqa_s1_q, irqa_s2_q, irqb_s1_q, irqb_s2_q, err_s1_q, err_s2_q;
  logic xa_busy, xb_busy;
  logic xa_start, xb_start;
  logic wake_status_a_q, wake_status_b_q;
  logic wake_enable_a_q, wake_enable_b_q;
  logic wake_pin_enable_q, wake_pin_polarity_q, wake_pin_buffer_q;
  logic wake_pin_pulse_select_q, auto_wake_enable_q, wake_irq_enable_q;
  logic [srwn_pkg::SRWN_MAP_W-1:0] wake_pin_map_q;
  logic wake_irq_status_q, wake_evt, wake_evt_q;
  logic [26:0] pulse_cnt_q;
  logic wake_active;
  logic wr_rst, wr_pc, wr_ie, wr_is;
  logic [31:0] pc_rd, is_rd;

  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      core_done_s1_q <= 1'b0;
      core_done_s2_q <= 1'b0;
      chip_done_s1_q <= 1'b0;
      chip_done_s2_q <= 1'b0;
      irqa_s1_q <= 1'b0;
      irqa_s2_q <= 1'b0;
      irqb_s1_q <= 1'b0;
      irqb_s2_q <= 1'b0;
      err_s1_q <= 1'b0;
      err_s2_q <= 1'b0;
    end else begin
      core_done_s1_q <= core_done_i;
      core_done_s2_q <= core_done_s1_q;
      chip_done_s1_q <= chip_done_i;
      chip_done_s2_q <= chip_done_s1_q;
      irqa_s1_q <= port_a_xcvr_irq_i;
      irqa_s2_q <= irqa_s1_q;
      irqb_s1_q <= port_b_xcvr_irq_i;
      irqb_s2_q <= irqb_s1_q;
      err_s1_q <= eeprom_load_err_i;
      err_s2_q <= err_s1_q;
    end
  end

  // --------------------------------------------------------------------------
  // Write decode; byte lane 0 carries all reset bits
  // --------------------------------------------------------------------------
  assign wr_rst = reg_wr_i && reg_be_i[0] && reg_addr_i == srwn_pkg::SRWN_SOFT_RESET_REG_OFS;
  assign wr_pc = reg_wr_i && reg_addr_i == srwn_pkg::SRWN_PWR_CTL_OFS;
  assign wr_ie = reg_wr_i && reg_addr_i == srwn_pkg::SRWN_IRQ_EN_OFS;
  assign wr_is = reg_wr_i && reg_addr_i == srwn_pkg::SRWN_IRQ_STS_OFS;
  assign xa_start = wr_rst && !xa_q && reg_wdata_i[srwn_pkg::SRWN_BIT_XA];
  assign xb_start = wr_rst && !xb_q && reg_wdata_i[srwn_pkg::SRWN_BIT_XB];

  // --------------------------------------------------------------------------
  // Self-clearing reset bits
  // --------------------------------------------------------------------------
  // Core reset: set by write, cleared when core reports done
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      core_q <= 1'b0;
    end else if (!core_q) begin
      core_q <= wr_rst && reg_wdata_i[srwn_pkg::SRWN_BIT_CORE];
    end else if (core_done_s2_q) begin
      core_q <= 1'b0;
    end
  end

  // Chip logic reset: set by write, cleared on release
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      chip_q <= 1'b0;
    end else if (!chip_q) begin
      chip_q <= wr_rst && reg_wdata_i[srwn_pkg::SRWN_BIT_CHIP];
    end else if (chip_done_s2_q) begin
      chip_q <= 1'b0;
    end
  end

  srwn_hold_timer #(
    .HOLD_CYC(XCVR_HOLD_CYC)
  ) u_hold_a (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .start_i(xa_start),
    .busy_o(xa_busy)
  );

  srwn_hold_timer #(
    .HOLD_CYC(XCVR_HOLD_CYC)
  ) u_hold_b (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .start_i(xb_start),
    .busy_o(xb_busy)
  );

  // Transceiver bits follow their hold timers
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      xa_q <= 1'b0;
      xb_q <= 1'b0;
    end else begin
      xa_q <= xa_busy;
      xb_q <= xb_busy;
    end
  end

  // Reset outputs
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      core_controller_reset_o <= 1'b0;
      port_a_transceiver_reset_o <= 1'b0;
      port_b_transceiver_reset_o <= 1'b0;
      chip_logic_reset_o <= 1'b0;
      eeprom_abort_o <= 1'b0;
      eeprom_reload_o <= 1'b0;
      host_if_enable_o <= 1'b1;
    end else begin
      core_controller_reset_o <= core_q;
      port_a_transceiver_reset_o <= xa_busy;
      port_b_transceiver_reset_o <= xb_busy;
      chip_logic_reset_o <= chip_q;
      eeprom_abort_o <= !chip_q && wr_rst && reg_wdata_i[srwn_pkg::SRWN_BIT_CHIP];
      eeprom_reload_o <= chip_q && chip_done_s2_q;
      host_if_enable_o <= !core_q;
    end
  end

  // --------------------------------------------------------------------------
  // Power control register; chip logic reset clears it except wake status
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || chip_q) begin
      wake_enable_a_q <= 1'b0;
      wake_enable_b_q <= 1'b0;
      wake_pin_enable_q <= 1'b0;
      wake_pin_polarity_q <= 1'b0;
      wake_pin_buffer_q <= 1'b0;
      wake_pin_pulse_select_q <= 1'b0;
      auto_wake_enable_q <= 1'b0;
      wake_pin_map_q <= '0;
    end else if (wr_pc) begin
      wake_enable_a_q <= reg_wdata_i[srwn_pkg::SRWN_PC_ENA];
      wake_enable_b_q <= reg_wdata_i[srwn_pkg::SRWN_PC_ENB];
      wake_pin_enable_q <= reg_wdata_i[srwn_pkg::SRWN_PC_EN];
      wake_pin_polarity_q <= reg_wdata_i[srwn_pkg::SRWN_PC_POL];
      wake_pin_buffer_q <= reg_wdata_i[srwn_pkg::SRWN_PC_BUF];
      wake_pin_pulse_select_q <= reg_wdata_i[srwn_pkg::SRWN_PC_IND];
      auto_wake_enable_q <= reg_wdata_i[srwn_pkg::SRWN_PC_AUTO];
      wake_pin_map_q <= reg_wdata_i[srwn_pkg::SRWN_PC_MAP_LO +: srwn_pkg::SRWN_MAP_W];
    end
  end

  // Wake status: any irq sets; write one clears; set wins over clear
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      wake_status_a_q <= 1'b0;
      wake_status_b_q <= 1'b0;
    end else begin
      wake_status_a_q <= irqa_s2_q || (wake_status_a_q &&
        !(wr_pc && reg_wdata_i[srwn_pkg::SRWN_PC_STA]));
      wake_status_b_q <= irqb_s2_q || (wake_status_b_q &&
        !(wr_pc && reg_wdata_i[srwn_pkg::SRWN_PC_STB]));
    end
  end

  // Wake irq status and enable
  assign wake_evt = (wake_status_a_q && wake_enable_a_q) ||
    (wake_status_b_q && wake_enable_b_q);
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      wake_irq_status_q <= 1'b0;
      wake_evt_q <= 1'b0;
    end else begin
      wake_evt_q <= wake_evt;
      wake_irq_status_q <= wake_evt || (wake_irq_status_q &&
        !(wr_is && reg_wdata_i[srwn_pkg::SRWN_IRQ_WAKE]));
    end
  end

  // Wake irq enable is an ordinary control bit, so chip logic reset clears it
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || chip_q) begin
      wake_irq_enable_q <= 1'b0;
    end else if (wr_ie) begin
      wake_irq_enable_q <= reg_wdata_i[srwn_pkg::SRWN_IRQEN_WAKE];
    end
  end

  // --------------------------------------------------------------------------
  // Wake pin drive
  // --------------------------------------------------------------------------
  // Pulse timer restarts on each rising wake event
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      pulse_cnt_q <= '0;
    end else if (wake_evt && !wake_evt_q) begin
      pulse_cnt_q <= 27'(PULSE_CYC);
    end else if (pulse_cnt_q != '0) begin
      pulse_cnt_q <= pulse_cnt_q - 27'h000_0001;
    end
  end

  assign wake_active = wake_pin_pulse_select_q ? (pulse_cnt_q != '0) : wake_evt;

  // Route to mapped pin; index zero means unmapped
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      wake_pin_out_o <= 8'h00;
      wake_pin_oe_o <= 8'h00;
    end else begin
      wake_pin_out_o <= 8'h00;
      wake_pin_oe_o <= 8'h00;
      if (wake_pin_enable_q && wake_pin_map_q != '0) begin
        if (wake_pin_buffer_q) begin
          wake_pin_out_o[wake_pin_map_q] <= wake_active ^ !wake_pin_polarity_q;
          wake_pin_oe_o[wake_pin_map_q] <= 1'b1;
        end else begin
          wake_pin_out_o[wake_pin_map_q] <= 1'b0;
          wake_pin_oe_o[wake_pin_map_q] <= wake_active;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      host_irq_o <= 1'b0;
      auto_wake_o <= 1'b0;
      error_led_force_o <= 1'b0;
    end else begin
      host_irq_o <= (wake_irq_status_q && wake_irq_enable_q) || irqa_s2_q || irqb_s2_q;
      auto_wake_o <= auto_wake_enable_q && wake_evt;
      error_led_force_o <= err_s2_q;
    end
  end

  // --------------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------------
  always_comb begin
    pc_rd = srwn_pkg::SRWN_ZERO;
    pc_rd[srwn_pkg::SRWN_PC_EN] = wake_pin_enable_q;
    pc_rd[srwn_pkg::SRWN_PC_POL] = wake_pin_polarity_q;
    pc_rd[srwn_pkg::SRWN_PC_BUF] = wake_pin_buffer_q;
    pc_rd[srwn_pkg::SRWN_PC_IND] = wake_pin_pulse_select_q;
    pc_rd[srwn_pkg::SRWN_PC_AUTO] = auto_wake_enable_q;
    pc_rd[srwn_pkg::SRWN_PC_ENA] = wake_enable_a_q;
    pc_rd[srwn_pkg::SRWN_PC_ENB] = wake_enable_b_q;
    pc_rd[srwn_pkg::SRWN_PC_MAP_LO +: srwn_pkg::SRWN_MAP_W] = wake_pin_map_q;
    pc_rd[srwn_pkg::SRWN_PC_STA] = wake_status_a_q;
    pc_rd[srwn_pkg::SRWN_PC_STB] = wake_status_b_q;
    is_rd = srwn_pkg::SRWN_ZERO;
    is_rd[srwn_pkg::SRWN_IRQ_XA] = irqa_s2_q;
    is_rd[srwn_pkg::SRWN_IRQ_XB] = irqb_s2_q;
    is_rd[srwn_pkg::SRWN_IRQ_WAKE] = wake_irq_status_q;
  end

  // Registered read data; reset register reads at all times
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= srwn_pkg::SRWN_ZERO;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        srwn_pkg::SRWN_SOFT_RESET_REG_OFS: begin
          reg_rdata_o <= {25'h000_0000, core_q, 3'h0, xb_q, xa_q, chip_q};
        end
        srwn_pkg::SRWN_PWR_CTL_OFS: begin
          reg_rdata_o <= pc_rd;
        end
        srwn_pkg::SRWN_IRQ_STS_OFS: begin
          reg_rdata_o <= is_rd;
        end
        srwn_pkg::SRWN_IRQ_EN_OFS: begin
          reg_rdata_o <= {14'h0000, wake_irq_enable_q, 17'h0_0000};
        end
        default: begin
          reg_rdata_o <= srwn_pkg::SRWN_ZERO;
        end
      endcase
    end
  end
endmodule

// ===== srwn_top_sva.sv
// Concurrent checks on the ports of the soft reset and wake block
`timescale 1ns/10ps
module srwn_top_sva #(
  parameter int XCVR_HOLD_CYC = 20,
  parameter int PULSE_CYC = 50
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic core_done_i,
  input wire logic eeprom_load_err_i,
  input wire logic port_a_xcvr_irq_i,
  input wire logic core_controller_reset_o,
  input wire logic port_a_transceiver_reset_o,
  input wire logic port_b_transceiver_reset_o,
  input wire logic chip_logic_reset_o,
  input wire logic eeprom_abort_o,
  input wire logic eeprom_reload_o,
  input wire logic host_if_enable_o,
  input wire logic host_irq_o,
  input wire logic error_led_force_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  logic [31:0] hold_a_q;
  logic [31:0] hold_b_q;
  // Count how long each transceiver reset has been high
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || !port_a_transceiver_reset_o)
      hold_a_q <= 32'h0000_0000;
    else
      hold_a_q <= hold_a_q + 32'h0000_0001;
  end
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || !port_b_transceiver_reset_o)
      hold_b_q <= 32'h0000_0000;
    else
      hold_b_q <= hold_b_q + 32'h0000_0001;
  end
  a_core_rst_hold: assert property (
    (!core_done_i)[*3] ##0 core_controller_reset_o |=> core_controller_reset_o)
    else $error("core reset released before done");
  a_xa_hold_min: assert property (
    $fell(port_a_transceiver_reset_o) |-> hold_a_q >= 32'(XCVR_HOLD_CYC))
    else $error("port a reset too short");
  a_xb_hold_min: assert property (
    $fell(port_b_transceiver_reset_o) |-> hold_b_q >= 32'(XCVR_HOLD_CYC))
    else $error("port b reset too short");
  a_host_if_gate: assert property (
    $rose(core_controller_reset_o) |-> !host_if_enable_o)
    else $error("host interface on during core reset");
  a_abort_pulse: assert property (
    eeprom_abort_o |=> !eeprom_abort_o)
    else $error("abort longer than one cycle");
  a_abort_chip: assert property (
    eeprom_abort_o |-> ##[0:2] chip_logic_reset_o)
    else $error("abort without chip reset");
  a_reload_release: assert property (
    $fell(chip_logic_reset_o) |-> (##[0:2] eeprom_reload_o)
      or ($past(eeprom_reload_o) || $past(eeprom_reload_o, 2)))
    else $error("no reload at chip reset release");
  a_irq_a_pin: assert property (
    port_a_xcvr_irq_i[*4] |-> host_irq_o)
    else $error("port a irq not on host irq");
  a_led_force: assert property (
    eeprom_load_err_i[*4] |-> error_led_force_o)
    else $error("error led not forced");
endmodule
bind srwn_top srwn_top_sva #(.XCVR_HOLD_CYC(XCVR_HOLD_CYC), .PULSE_CYC(PULSE_CYC)) u_sva (
  .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .core_done_i(core_done_i),
  .eeprom_load_err_i(eeprom_load_err_i), .port_a_xcvr_irq_i(port_a_xcvr_irq_i),
  .core_controller_reset_o(core_controller_reset_o),
  .port_a_transceiver_reset_o(port_a_transceiver_reset_o),
  .port_b_transceiver_reset_o(port_b_transceiver_reset_o),
  .chip_logic_reset_o(chip_logic_reset_o), .eeprom_abort_o(eeprom_abort_o),
  .eeprom_reload_o(eeprom_reload_o), .host_if_enable_o(host_if_enable_o),
  .host_irq_o(host_irq_o), .error_led_force_o(error_led_force_o));

// ===== srwn_far_model.sv
// Far-side model: controller core, chip logic and two transceivers
`timescale 1ns/10ps
module srwn_far_model (
  input wire logic sys_clk_i,
  input wire logic core_reset_i,
  input wire logic chip_reset_i,
  input wire logic slow_i,
  input wire logic event_a_i,
  input wire logic event_b_i,
  output logic core_done_o,
  output logic chip_done_o,
  output logic xcvr_irq_a_o,
  output logic xcvr_irq_b_o
);
  int core_cnt = 0;
  int chip_cnt = 0;
  // Core done rises a short or long time after reset, chip done a short time; both fall with reset
  always @(posedge sys_clk_i) begin
    core_cnt <= (core_reset_i === 1'b1) ? core_cnt + 1 : 0;
    chip_cnt <= (chip_reset_i === 1'b1) ? chip_cnt + 1 : 0;
    core_done_o <= (core_reset_i === 1'b1) && core_cnt >= (slow_i ? 40 : 3);
    chip_done_o <= (chip_reset_i === 1'b1) && chip_cnt >= 3;
  end
  // Energy or wake frame seen raises the flag on the next clock, even if already present
  always @(posedge sys_clk_i) begin
    xcvr_irq_a_o <= event_a_i;
    xcvr_irq_b_o <= event_b_i;
  end
endmodule

// ===== testbench.sv
// Self-checking bench for the soft reset and wake block
`timescale 1ns/10ps
module testbench;
  localparam int HOLD = 20;
  localparam int PULSE = 50;
  localparam logic [11:0] RST = srwn_pkg::SRWN_SOFT_RESET_REG_OFS;
  localparam logic [11:0] PC = srwn_pkg::SRWN_PWR_CTL_OFS;
  localparam logic [11:0] IS = srwn_pkg::SRWN_IRQ_STS_OFS;
  localparam logic [11:0] IE = srwn_pkg::SRWN_IRQ_EN_OFS;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [11:0] reg_addr_i = 12'h000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [3:0] reg_be_i = 4'hf;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic eeprom_load_err_i = 1'b0;
  logic slow = 1'b0;
  logic ev_a = 1'b0;
  logic ev_b = 1'b0;
  logic saw_abort = 1'b0;
  logic saw_reload = 1'b0;
  logic [31:0] reg_rdata_o;
  logic core_done_i, chip_done_i, port_a_xcvr_irq_i, port_b_xcvr_irq_i;
  logic core_controller_reset_o, port_a_transceiver_reset_o, port_b_transceiver_reset_o;
  logic chip_logic_reset_o, eeprom_abort_o, eeprom_reload_o, host_if_enable_o;
  logic host_irq_o, auto_wake_o, error_led_force_o;
  logic [7:0] wake_pin_out_o, wake_pin_oe_o;
  int n_mismatch = 0;
  int total_checks = 0;
  srwn_top #(.XCVR_HOLD_CYC(HOLD), .PULSE_CYC(PULSE)) uut (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_be_i(reg_be_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .core_done_i(core_done_i),
    .chip_done_i(chip_done_i), .eeprom_load_err_i(eeprom_load_err_i),
    .core_controller_reset_o(core_controller_reset_o),
    .port_a_transceiver_reset_o(port_a_transceiver_reset_o),
    .port_b_transceiver_reset_o(port_b_transceiver_reset_o),
    .chip_logic_reset_o(chip_logic_reset_o), .eeprom_abort_o(eeprom_abort_o),
    .eeprom_reload_o(eeprom_reload_o), .host_if_enable_o(host_if_enable_o),
    .port_a_xcvr_irq_i(port_a_xcvr_irq_i), .port_b_xcvr_irq_i(port_b_xcvr_irq_i),
    .host_irq_o(host_irq_o), .auto_wake_o(auto_wake_o),
    .error_led_force_o(error_led_force_o), .wake_pin_out_o(wake_pin_out_o),
    .wake_pin_oe_o(wake_pin_oe_o));
  srwn_far_model u_far (
    .sys_clk_i(sys_clk_i), .core_reset_i(core_controller_reset_o),
    .chip_reset_i(chip_logic_reset_o), .slow_i(slow), .event_a_i(ev_a), .event_b_i(ev_b),
    .core_done_o(core_done_i), .chip_done_o(chip_done_i),
    .xcvr_irq_a_o(port_a_xcvr_irq_i), .xcvr_irq_b_o(port_b_xcvr_irq_i));
  // Clock and pulse monitors
  initial begin
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    if (eeprom_abort_o === 1'b1)
      saw_abort <= 1'b1;
    if (eeprom_reload_o === 1'b1)
      saw_reload <= 1'b1;
  end
  // ----------------------------------------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Wait n edges, then step past the edge so outputs are settled
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] be);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_be_i <= be;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    v = reg_rdata_o;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    chk(v, exp);
  endtask
  // Poll the reset register until the masked bits clear, bounded
  task automatic wait_clr(input logic [31:0] m);
    logic [31:0] v;
    int i;
    i = 0;
    do begin
      rd(RST, v);
      i++;
    end while ((v & m) !== 32'h0000_0000 && i < 100);
    chk(v & m, 32'h0000_0000);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    n_mismatch++;
    summarize();
  end
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    rchk(RST, 32'h0000_0000);
    rchk(PC, 32'h0000_0000);
    rchk(12'h100, 32'h0000_0000);
    slow <= 1'b1;
    wr(RST, 32'h0000_0040, 4'h1);
    rchk(RST, 32'h0000_0040);
    chk({31'h0, host_if_enable_o}, 32'h0000_0000);
    wr(RST, 32'h0000_0000, 4'h1);
    rchk(RST, 32'h0000_0040);
    wait_clr(32'h0000_0040);
    chk({31'h0, host_if_enable_o}, 32'h0000_0001);
    slow <= 1'b0;
    wr(RST, 32'h0000_0006, 4'he);
    rchk(RST, 32'h0000_0000);
    for (int i = 1; i <= 2; i++) begin
      wr(RST, 32'h0000_0001 << i, 4'h1);
      rchk(RST, 32'h0000_0001 << i);
      wr(RST, 32'h0000_0000, 4'h1);
      rchk(RST, 32'h0000_0001 << i);
      wait_clr(32'h0000_0001 << i);
    end
    wr(PC, 32'h0000_110e, 4'hf);
    ev_a <= 1'b1;
    idle(8);
    rchk(IS, 32'h0402_0000);
    ev_a <= 1'b0;
    idle(8);
    chk({31'h0, host_irq_o}, 32'h0000_0000);
    rchk(PC, 32'h0001_110e);
    chk({31'h0, |(wake_pin_oe_o & wake_pin_out_o)}, 32'h0000_0001);
    wr(IE, 32'h0002_0000, 4'hf);
    idle(3);
    chk({31'h0, host_irq_o}, 32'h0000_0001);
    wr(PC, 32'h0000_110c, 4'hf);
    idle(3);
    chk({24'h00_0000, wake_pin_oe_o}, 32'h0000_0000);
    wr(PC, 32'h0000_1126, 4'hf);
    idle(3);
    chk({30'h0, |wake_pin_oe_o, |wake_pin_out_o}, 32'h0000_0002);
    chk({31'h0, auto_wake_o}, 32'h0000_0001);
    wr(PC, 32'h0001_111a, 4'hf);
    ev_a <= 1'b1;
    idle(6);
    chk({30'h0, |wake_pin_oe_o, |(wake_pin_oe_o & wake_pin_out_o)}, 32'h0000_0002);
    ev_a <= 1'b0;
    idle(PULSE + 4);
    chk({30'h0, |wake_pin_oe_o, |(wake_pin_oe_o & wake_pin_out_o)}, 32'h0000_0003);
    wr(PC, 32'h0001_0200, 4'hf);
    wr(IS, 32'h0002_0000, 4'hf);
    ev_b <= 1'b1;
    idle(8);
    rchk(IS, 32'h0802_0000);
    ev_b <= 1'b0;
    idle(8);
    rchk(PC, 32'h0002_0200);
    wr(RST, 32'h0000_0001, 4'h1);
    wait_clr(32'h0000_0001);
    chk({30'h0, saw_abort, saw_reload}, 32'h0000_0003);
    rchk(PC, 32'h0002_0000);
    rchk(IE, 32'h0000_0000);
    wr(PC, 32'h0002_0000, 4'hf);
    wr(IS, 32'h0002_0000, 4'hf);
    rchk(IS, 32'h0000_0000);
    rchk(PC, 32'h0000_0000);
    @(posedge sys_clk_i);
    eeprom_load_err_i <= 1'b1;
    idle(5);
    chk({31'h0, error_led_force_o}, 32'h0000_0001);
    summarize();
  end
endmodule
